// >>> bench/host_model.sv
// Host controller model driving the serial command link
module host_model(
	input wire clock_in,
	input wire data_in,
	input wire oe_in,
	output logic cs_n_out = 1'b1,
	output logic sclk_out = 1'b0,
	output logic data_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Bit period of eight clocks gives a 400 ns shift clock
	task automatic frame(input int n, input [7:0] d, output [7:0] got);
		got = 8'h00;
		@(posedge clock_in) cs_n_out <= 1'b0;
		repeat (4) @(posedge clock_in);
		for (int i = n - 1; i >= 0; i--) begin
			data_out <= d[i];
			sclk_out <= 1'b0;
			repeat (3) @(posedge clock_in);
			// Undriven output reads as unknown so a missing enable fails
			@(negedge clock_in) got = {got[6:0], oe_in ? data_in : 1'bx};
			@(posedge clock_in) sclk_out <= 1'b1;
			repeat (4) @(posedge clock_in);
		end
		cs_n_out <= 1'b1;
		sclk_out <= 1'b0;
		data_out <= ~data_out;
		repeat (6) @(posedge clock_in);
	endtask
endmodule

// >>> bench/predriver_checker.sv
// Port assertions for the predriver serial and fault control block
module predriver_checker(
	input wire clock_in,
	input wire resetn_in,
	input wire chip_sel_n_in,
	input wire shift_clk_in,
	input wire ser_out,
	input wire ser_out_oe_out,
	input wire [3:0] par_ctrl_in,
	input wire [3:0] drain_sense,
	input wire battery_over_in,
	input wire battery_under_in,
	input wire [3:0] gate_out,
	input wire fault_flag_n,
	input wire fault_flag_oe_out,
	input wire [3:0] cmd_latch_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	wire bat = battery_over_in | battery_under_in;
	AST_RESET: assert property ($rose(resetn_in) |-> gate_out == 4'h0 && !ser_out_oe_out)
		else $error("not reset");
	AST_FLAG_PIN: assert property (fault_flag_n == 1'b0)
		else $error("flag pin drives high");
	AST_BATT_OFF: assert property (bat [*5] |-> gate_out == 4'h0 && fault_flag_oe_out)
		else $error("battery fault ignored");
	AST_OE_OFF: assert property (chip_sel_n_in [*4] |-> !ser_out_oe_out)
		else $error("output driven while idle");
	AST_OE_ON: assert property (!chip_sel_n_in [*4] |-> ser_out_oe_out)
		else $error("output not driven in frame");
	AST_CMD_HOLD: assert property (chip_sel_n_in [*6] |=> $stable(cmd_latch_out))
		else $error("command moved while idle");
	AST_SHIFT_EDGE: assert property ((!chip_sel_n_in && !shift_clk_in) [*6] |=> $stable(ser_out))
		else $error("shift without clock rise");
	AST_PAR_OR: assert property ((par_ctrl_in == 4'h0) [*4] |-> (gate_out & ~cmd_latch_out) == 4'h0)
		else $error("gate on without request");
	AST_PAR_ON: assert property ((par_ctrl_in[2] && !drain_sense[2] && !bat) [*5] |-> gate_out[2])
		else $error("parallel request lost");
endmodule

bind predriver_serial_fault_ctl predriver_checker i_chk(.clock_in(clock_in), .resetn_in(resetn_in),
	.chip_sel_n_in(chip_sel_n_in), .shift_clk_in(shift_clk_in), .ser_out(ser_out),
	.ser_out_oe_out(ser_out_oe_out), .par_ctrl_in(par_ctrl_in), .drain_sense(drain_sense),
	.battery_over_in(battery_over_in), .battery_under_in(battery_under_in), .gate_out(gate_out),
	.fault_flag_n(fault_flag_n), .fault_flag_oe_out(fault_flag_oe_out), .cmd_latch_out(cmd_latch_out));

// >>> bench/test_predriver_serial_fault_ctl.sv
// Self-checking bench for the predriver serial and fault control block
module test_predriver_serial_fault_ctl;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in = 0, resetn_in = 0, ref_source_sel = 0, battery_over_in = 0, battery_under_in = 0;
	logic [3:0] par_ctrl_in = 4'h0, drain_sense = 4'h0, ext_fault_ref = 4'hF, int_fault_ref_in = 4'hF;
	wire chip_sel_n_in, shift_clk_in, ser_in, ser_out, ser_out_oe_out, fault_flag_n, fault_flag_oe_out;
	wire [3:0] gate_out, cmd_latch_out, gate_pulse;
	logic [7:0] got;
	int err_count = 0, n_tests = 0, cycles = 0, pulse_hi = 0;
	always #25 clock_in = ~clock_in;
	predriver_serial_fault_ctl #(.DEGLITCH_CYCLES(2)) i_dut(.clock_in(clock_in), .resetn_in(resetn_in),
		.chip_sel_n_in(chip_sel_n_in), .shift_clk_in(shift_clk_in), .ser_in(ser_in), .ser_out(ser_out),
		.ser_out_oe_out(ser_out_oe_out), .par_ctrl_in(par_ctrl_in), .drain_sense(drain_sense),
		.ref_source_sel(ref_source_sel), .ext_fault_ref(ext_fault_ref), .int_fault_ref_in(int_fault_ref_in),
		.battery_over_in(battery_over_in), .battery_under_in(battery_under_in), .gate_out(gate_out),
		.fault_flag_n(fault_flag_n), .fault_flag_oe_out(fault_flag_oe_out), .cmd_latch_out(cmd_latch_out));
	// Pulsing variant shares every input; only its gates are watched
	predriver_serial_fault_ctl #(.DEGLITCH_CYCLES(2), .PULSE_VARIANT(1), .PULSE_PERIOD(8), .PULSE_ON(2)) i_dut_pulse(
		.clock_in(clock_in), .resetn_in(resetn_in), .chip_sel_n_in(chip_sel_n_in), .shift_clk_in(shift_clk_in),
		.ser_in(ser_in), .ser_out(), .ser_out_oe_out(), .par_ctrl_in(par_ctrl_in), .drain_sense(drain_sense),
		.ref_source_sel(ref_source_sel), .ext_fault_ref(ext_fault_ref), .int_fault_ref_in(int_fault_ref_in),
		.battery_over_in(battery_over_in), .battery_under_in(battery_under_in), .gate_out(gate_pulse),
		.fault_flag_n(), .fault_flag_oe_out(), .cmd_latch_out());
	host_model i_host(.clock_in(clock_in), .data_in(ser_out), .oe_in(ser_out_oe_out),
		.cs_n_out(chip_sel_n_in), .sclk_out(shift_clk_in), .data_out(ser_in));
	task w(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	// Compares on the falling edge so outputs have settled, returns on a rising edge for the next stimulus
	task chk(input [7:0] g, input [7:0] e);
		@(negedge clock_in) n_tests++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
		@(posedge clock_in);
	endtask
	task summarize;
		$display("Checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			$display("BAD %0t timeout", $time);
			summarize();
		end
	end
	initial begin
		w(1); chk({ser_out_oe_out, fault_flag_oe_out, 2'b00, gate_out}, 8'h00);
		w(4); resetn_in <= 1'b1;
		w(4); drain_sense <= 4'h6;
		w(8); chk({7'h0, fault_flag_oe_out}, 8'h01);
		i_host.frame(4, 8'h00, got); chk(got, 8'h06);
		ref_source_sel <= 1'b1;
		ext_fault_ref <= 4'h9;
		w(8); i_host.frame(4, 8'h00, got); chk({got[3:0], 3'h0, fault_flag_oe_out}, 8'h00);
		$display("Test fault report ended");
		w(1); ref_source_sel <= 1'b0;
		drain_sense <= 4'h0;
		w(8); i_host.frame(4, 8'h0A, got); chk({got[3:0], gate_out}, 8'h0A);
		chk({4'h0, cmd_latch_out}, 8'h0A);
		i_host.frame(8, 8'h5C, got); chk(got, 8'h05);
		chk({4'h0, cmd_latch_out}, 8'h0C);
		$display("Test command ended");
		i_host.frame(4, 8'h01, got); drain_sense <= 4'h1;
		w(10); chk({3'h0, fault_flag_oe_out, gate_out}, 8'h10);
		// Two of every eight cycles on while the short stands
		for (int k = 0; k < 16; k++) @(negedge clock_in) pulse_hi += gate_pulse[0];
		chk(pulse_hi[7:0], 8'h04);
		w(1); drain_sense <= 4'h0;
		w(4); i_host.frame(4, 8'h01, got); chk({got[3:0], gate_out}, 8'h11);
		// An open load that appears mid-frame stays out of that frame
		fork
			i_host.frame(4, 8'h00, got);
			begin
				w(8);
				drain_sense <= 4'h8;
			end
		join
		chk({3'h0, fault_flag_oe_out, got[3:0]}, 8'h10);
		i_host.frame(4, 8'h00, got); chk(got, 8'h08);
		drain_sense <= 4'h0;
		$display("Test short ended");
		for (int i = 0; i < 2; i++) begin
			battery_over_in <= (i == 0);
			battery_under_in <= (i == 1);
			w(4); par_ctrl_in <= 4'hF;
			drain_sense <= 4'h3;
			w(8); chk({3'h0, fault_flag_oe_out, gate_out}, 8'h10);
			i_host.frame(4, 8'h00, got); chk(got, 8'h00);
			w(1); drain_sense <= 4'h0;
			w(4); battery_over_in <= 1'b0;
			battery_under_in <= 1'b0;
			w(8); chk({4'h0, gate_out}, 8'h0F);
			w(1); par_ctrl_in <= 4'h0;
		end
		$display("Test battery ended");
		i_host.frame(4, 8'h0F, got); chk({4'h0, cmd_latch_out}, 8'h0F);
		resetn_in <= 1'b0;
		w(2); chk({ser_out_oe_out, fault_flag_oe_out, 2'b00, cmd_latch_out | gate_out}, 8'h00);
		resetn_in <= 1'b1;
		w(4); chk({ser_out_oe_out, 3'h0, cmd_latch_out}, 8'h00);
		$display("Test reset ended");
		summarize();
	end
endmodule

// >>> inc/predriver_regs.vh
// Constants for the four-channel predriver serial and fault control block
// Contract
// - Serial input is sampled into the shift register on each shift clock rise.
// - Command bit 1 turns a gate on, 0 turns it off.
// - Four fault bits shift out on serial output while commands shift in.
// - A shifted fault bit is 1 for fault, 0 for none.
// - With chip select high, fault bits track live fault state.
// - Chip select fall enables output, loads fault bits, refreshes fault flag.
// - Faults arising while chip select is low never enter the shift register.
// - Chip select rise latches last four bits, tri-states output, re-arms faults.
// - In a chain, shifted-in bits emerge on serial output after fault bits.
// - Each parallel input drives its gate without shift clock or chip select.
// - A channel is on when its latched command or parallel input asks.
// - Drain compare is a short fault when on, open fault when off.
// - Reference select low picks internal reference, high picks external.
// - Shutdown variant turns a confirmed shorted channel off and flags it.
// - Pulsing variant drives a shorted channel with low-duty pulses while shorted.
// - A short is flagged only after persisting for the deglitch interval.
// - Battery over or under voltage disables all channels and asserts flag.
// - Battery faults are not shifted out and suppress load-fault reporting.
// - Active-low reset clears every register and flag, gates forced off. The code resets the chip select synchroniser bit and cs_n_d_ff high instead.
// - Fault flag is open-drain real-time indication, wire-OR capable.
`ifndef PREDRIVER_REGS_VH
`define PREDRIVER_REGS_VH
`define CHAN_COUNT 4
`define FAULT_RESET 4'h0
`define CMD_RESET 4'h0
`define CLK_FREQ_HZ 20000000
`define SHORT_DEGLITCH_TIME_NS 1000
`define SHORT_DEGLITCH_CYCLES ((`SHORT_DEGLITCH_TIME_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define PULSE_PERIOD_CYCLES 64
`define PULSE_ON_CYCLES 4
`endif

// >>> rtl/chan_fault.v
// Per-channel short deglitch, short reaction and gate drive
`include "predriver_regs.vh"
module chan_fault #(
	parameter DEGLITCH_CYCLES = `SHORT_DEGLITCH_CYCLES,
	parameter PULSE_VARIANT = 0
) (
	// Clock and reset
	input wire clock_in,
	input wire resetn_in,
	// Channel
	input wire request_in,
	input wire drain_fault_in,
	input wire battery_fault_in,
	input wire pulse_on_in,
	input wire rearm_in,
	output wire gate_out,
	output wire fault_out
);
	localparam CW = 16;
	reg [CW-1:0] glitch_cnt_ff;
	reg short_ff;
	reg open_ff;
	wire want_on = request_in & ~battery_fault_in;
	// Comparator result is checked against the requested state, so a shut channel still sees its short
	wire short_raw = want_on & drain_fault_in;
	wire open_raw = ~want_on & drain_fault_in & ~short_ff;
	always @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			glitch_cnt_ff <= {CW{1'b0}};
			short_ff <= 1'b0;
			open_ff <= 1'b0;
		end else begin
			if (!short_raw) begin
				glitch_cnt_ff <= {CW{1'b0}};
			end else if (glitch_cnt_ff < DEGLITCH_CYCLES[CW-1:0]) begin
				glitch_cnt_ff <= glitch_cnt_ff + 16'h0001;
			end
			// Short latches until the frame end re-arms it, or in the pulsing variant until the short goes away; set wins over re-arm
			if (short_raw && glitch_cnt_ff >= DEGLITCH_CYCLES[CW-1:0] - 16'h0001) begin
				short_ff <= 1'b1;
			end else if (rearm_in || (PULSE_VARIANT != 0 && !short_raw)) begin
				short_ff <= 1'b0;
			end
			open_ff <= open_raw;
		end
	end
	// Shutdown variant drops the gate; pulsing variant chops it
	assign gate_out = want_on & (~short_ff | ((PULSE_VARIANT != 0) & pulse_on_in));
	assign fault_out = (short_ff | open_ff) & ~battery_fault_in;
endmodule

// >>> rtl/predriver_serial_fault_ctl.v
// Serial command and fault reporting core of the four-channel predriver
`include "predriver_regs.vh"
module predriver_serial_fault_ctl #(
	parameter CHANNELS = `CHAN_COUNT,
	parameter DEGLITCH_CYCLES = `SHORT_DEGLITCH_CYCLES,
	parameter PULSE_VARIANT = 0,
	parameter PULSE_PERIOD = `PULSE_PERIOD_CYCLES,
	parameter PULSE_ON = `PULSE_ON_CYCLES
) (
	// Clock and reset
	input wire clock_in,
	input wire resetn_in,
	// Serial link from controller
	input wire chip_sel_n_in,
	input wire shift_clk_in,
	input wire ser_in,
	output wire ser_out,
	output wire ser_out_oe_out,
	// Parallel control and sensing
	input wire [3:0] par_ctrl_in,
	input wire [3:0] drain_sense,
	input wire ref_source_sel,
	input wire [3:0] ext_fault_ref,
	input wire [3:0] int_fault_ref_in,
	input wire battery_over_in,
	input wire battery_under_in,
	// Outputs
	output wire [3:0] gate_out,
	output wire fault_flag_n,
	output wire fault_flag_oe_out,
	output wire [3:0] cmd_latch_out
);
	wire [9:0] async_bus;
	wire [9:0] sync_bus;
	assign async_bus = {chip_sel_n_in, shift_clk_in, ser_in, par_ctrl_in, ref_source_sel, battery_over_in,
		battery_under_in};
	// Chip select resets high in the synchroniser so reset release is not seen as a frame start
	sync2 #(.WIDTH(10), .RESET_VAL(10'h200)) u_sync (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.async_in(async_bus),
		.sync_out(sync_bus)
	);
	wire cs_n_s = sync_bus[9];
	wire sclk_s = sync_bus[8];
	wire sdi_s = sync_bus[7];
	wire [3:0] par_s = sync_bus[6:3];
	wire ref_sel_s = sync_bus[2];
	wire batt_s = sync_bus[1] | sync_bus[0];

	// Comparator inputs are synchronised before the reference select combines them
	wire [11:0] drain_sync;
	sync2 #(.WIDTH(12)) u_sync_drain (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.async_in({drain_sense, ext_fault_ref, int_fault_ref_in}),
		.sync_out(drain_sync)
	);
	wire [3:0] drain_cmp_s = drain_sync[11:8] & (ref_sel_s ? drain_sync[7:4] : drain_sync[3:0]);

	reg cs_n_d_ff;
	reg sclk_d_ff;
	reg [3:0] shift_ff;
	reg [3:0] cmd_ff;
	reg sdo_oe_ff;
	reg flag_ff;
	reg rearm_ff;
	reg [7:0] pulse_cnt_ff;
	wire cs_fall = cs_n_d_ff & ~cs_n_s;
	wire cs_rise = ~cs_n_d_ff & cs_n_s;
	wire sclk_rise = ~sclk_d_ff & sclk_s;
	wire [3:0] live_fault;
	wire pulse_on = (pulse_cnt_ff < PULSE_ON);

	always @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cs_n_d_ff <= 1'b1;
			sclk_d_ff <= 1'b0;
			shift_ff <= `FAULT_RESET;
			cmd_ff <= `CMD_RESET;
			sdo_oe_ff <= 1'b0;
			flag_ff <= 1'b0;
			rearm_ff <= 1'b0;
			pulse_cnt_ff <= 8'h00;
		end else begin
			cs_n_d_ff <= cs_n_s;
			sclk_d_ff <= sclk_s;
			rearm_ff <= cs_rise;
			pulse_cnt_ff <= (pulse_cnt_ff >= PULSE_PERIOD - 1) ? 8'h00 : pulse_cnt_ff + 8'h01;
			if (cs_n_s) begin
				// Idle: register follows live faults; chip select low freezes it
				shift_ff <= live_fault;
			end
			if (cs_fall) begin
				shift_ff <= live_fault;
				sdo_oe_ff <= 1'b1;
			end else if (!cs_n_s && sclk_rise) begin
				// Incoming bits push fault bits and upstream data out the top
				shift_ff <= {shift_ff[2:0], sdi_s};
			end
			if (cs_rise) begin
				cmd_ff <= shift_ff;
				sdo_oe_ff <= 1'b0;
			end
			flag_ff <= (|live_fault) | batt_s;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : chan
			chan_fault #(
				.DEGLITCH_CYCLES(DEGLITCH_CYCLES),
				.PULSE_VARIANT(PULSE_VARIANT)
			) u_chan (
				.clock_in(clock_in),
				.resetn_in(resetn_in),
				.request_in(cmd_ff[g] | par_s[g]),
				.drain_fault_in(drain_cmp_s[g]),
				.battery_fault_in(batt_s),
				.pulse_on_in(pulse_on),
				.rearm_in(rearm_ff),
				.gate_out(gate_out[g]),
				.fault_out(live_fault[g])
			);
		end
	endgenerate

	// MSB leaves first so fault bit 3 leads and the chained data trails
	assign ser_out = shift_ff[3];
	assign ser_out_oe_out = sdo_oe_ff;
	assign fault_flag_n = 1'b0;
	assign fault_flag_oe_out = flag_ff;
	assign cmd_latch_out = cmd_ff;
endmodule

// >>> rtl/sync2.v
// Two-stage synchroniser for a bus of asynchronous inputs
module sync2 #(
	parameter WIDTH = 1,
	// Lets an active-low pin start at its idle level, so no false edge follows reset
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	// Clock and reset
	input wire clock_in,
	input wire resetn_in,
	// Data
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;
	always @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_ff <= RESET_VAL;
			sync_ff <= RESET_VAL;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end
	assign sync_out = sync_ff;
endmodule
